// >>> hw/ocsc_apply.sv
// adds one signed correction to one signed sensor sample
`default_nettype none
module ocsc_apply (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic en, // compensation enable
  input wire logic signed [9:0] corr, // 10-bit signed correction
  input wire logic signed [15:0] raw, // uncorrected sample
  output logic signed [15:0] fixed // corrected sample
);
  import ocsc_pkg::*;
  logic signed [16:0] sum;
  logic signed [15:0] next_fixed;
  always_comb begin
    sum = 17'(raw) + 17'(corr);
    if (!en) begin
      next_fixed = raw;
    end else if (sum > 17'sh07FFF) begin
      next_fixed = 16'sh7FFF;
    end else if (sum < -17'sh08000) begin
      next_fixed = -16'sh8000;
    end else begin
      next_fixed = sum[15:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fixed <= 16'sh0000;
    end else begin
      fixed <= next_fixed;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ocsc_bank.sv
// offset compensation and step count register bank
`include "ocsc_consts.svh"
`default_nettype none
module ocsc_bank (
  input wire logic clk, // system clock
  input wire logic sys_rst, // power-on reset, synchronous
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire ocsc_pkg::ocsc_byte_t reg_wdata, // write data
  output ocsc_pkg::ocsc_byte_t reg_rdata, // read data
  input wire logic step_seen, // one-cycle pulse per detected step
  input wire logic foc_done, // calibration finished pulse
  input wire logic [55:0] foc_result, // seven computed correction bytes
  output logic foc_start, // calibration request pulse
  output logic busy, // nonvolatile transfer in progress
  input wire logic signed [15:0] acc_in_x, // accel x sample
  input wire logic signed [15:0] acc_in_y, // accel y sample
  input wire logic signed [15:0] acc_in_z, // accel z sample
  input wire logic signed [15:0] gyr_in_x, // gyro x sample
  input wire logic signed [15:0] gyr_in_y, // gyro y sample
  input wire logic signed [15:0] gyr_in_z, // gyro z sample
  output logic signed [15:0] acc_out_x, // corrected accel x
  output logic signed [15:0] acc_out_y, // corrected accel y
  output logic signed [15:0] acc_out_z, // corrected accel z
  output logic signed [15:0] gyr_out_x, // corrected gyro x
  output logic signed [15:0] gyr_out_y, // corrected gyro y
  output logic signed [15:0] gyr_out_z, // corrected gyro z
  output logic [10:0] stride_setting, // detector configuration
  output logic tally_en // step counting enable
);
  import ocsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  ocsc_byte_t corr [0:6];
  ocsc_byte_t next_corr [0:6];
  ocsc_byte_t stride_lo, stride_hi, next_stride_lo, next_stride_hi;
  logic [15:0] tally, next_tally;
  logic [7:0] tally_hi_hold, next_tally_hi_hold;
  ocsc_nvm_st_t st, next_st;
  logic [2:0] idx, next_idx;
  logic load_valid, next_load_valid;
  logic [2:0] load_idx, next_load_idx;
  logic soft_rst, next_soft_rst;
  ocsc_byte_t next_rdata;
  logic next_foc_start;
  ocsc_byte_t nvm_rd;
  logic nvm_wr;
  logic [2:0] nvm_addr;
  logic is_cmd;
  logic [2:0] wr_idx;
  ////////////////////////////////////////////////////////////////////////
  assign is_cmd = reg_wr && reg_addr == `OCSC_ADDR_CMD;
  assign wr_idx = 3'(reg_addr - `OCSC_ADDR_CORR_BASE);
  assign nvm_wr = st == OCSC_STORE;
  assign nvm_addr = idx;

  ocsc_nvm_mem u_nvm (
    .clk(clk),
    .wr_en(nvm_wr),
    .addr(nvm_addr),
    .wr_data(corr[idx]),
    .rd_data(nvm_rd)
  );

  // nonvolatile sequencer: load on reset/soft reset, store on command
  always_comb begin
    next_st = st;
    next_idx = idx;
    next_load_valid = 1'b0;
    next_load_idx = idx;
    next_soft_rst = is_cmd && reg_wdata == `OCSC_CMD_SOFTRESET;
    next_foc_start = 1'b0;
    case (st)
      OCSC_IDLE: begin
        if (soft_rst) begin
          next_st = OCSC_LOAD;
          next_idx = 3'h0;
        end else if (is_cmd && reg_wdata == `OCSC_CMD_PROG_NVM) begin
          next_st = OCSC_STORE;
          next_idx = 3'h0;
        end else if (is_cmd && reg_wdata == `OCSC_CMD_FOC) begin
          next_foc_start = 1'b1;
        end
      end
      OCSC_LOAD: begin
        next_load_valid = 1'b1;
        next_load_idx = idx;
        if (idx == 3'h6) begin
          next_st = OCSC_IDLE;
        end else begin
          next_idx = idx + 3'h1;
        end
      end
      OCSC_STORE: begin
        if (idx == 3'h6) begin
          next_st = OCSC_IDLE;
        end else begin
          next_idx = idx + 3'h1;
        end
      end
      default: next_st = OCSC_IDLE;
    endcase
    // soft reset is never dropped: it restarts the reload even mid-sequence
    if (soft_rst) begin
      next_st = OCSC_LOAD;
      next_idx = 3'h0;
    end
  end

  // correction bytes, by priority: nvm load, then host write, then calibration
  always_comb begin
    for (int i = 0; i < `OCSC_CORR_BYTES; i++) begin
      next_corr[i] = corr[i];
      if (foc_done) begin
        next_corr[i] = foc_result[i*8 +: 8];
      end
      if (reg_wr && reg_addr == `OCSC_ADDR_CORR_BASE + 8'(i)) begin
        next_corr[i] = reg_wdata;
      end
      if (load_valid && load_idx == 3'(i)) begin
        next_corr[i] = nvm_rd;
      end
    end
  end

  // detector setting and step tally
  always_comb begin
    next_stride_lo = stride_lo;
    next_stride_hi = stride_hi;
    next_tally = tally;
    next_tally_hi_hold = tally_hi_hold;
    if (reg_wr && reg_addr == `OCSC_ADDR_STRIDE_LO) begin
      next_stride_lo = reg_wdata;
    end
    if (reg_wr && reg_addr == `OCSC_ADDR_STRIDE_HI) begin
      next_stride_hi = reg_wdata & `OCSC_STRIDE_HI_MASK;
    end
    if (step_seen && stride_hi[`OCSC_BIT_TALLY_EN]) begin
      next_tally = tally + 16'h0001;
    end
    if (is_cmd && reg_wdata == `OCSC_CMD_TALLY_CLR) begin
      next_tally = `OCSC_TALLY_RESET;
    end
    if (reg_rd && reg_addr == `OCSC_ADDR_TALLY_LO) begin
      next_tally_hi_hold = tally[15:8];
    end
  end

  // register read port
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr >= `OCSC_ADDR_CORR_BASE &&
          reg_addr <= `OCSC_ADDR_CORR_LAST) begin
        next_rdata = corr[wr_idx];
      end else if (reg_addr == `OCSC_ADDR_TALLY_LO) begin
        next_rdata = tally[7:0];
      end else if (reg_addr == `OCSC_ADDR_TALLY_HI) begin
        next_rdata = tally_hi_hold;
      end else if (reg_addr == `OCSC_ADDR_STRIDE_LO) begin
        next_rdata = stride_lo;
      end else if (reg_addr == `OCSC_ADDR_STRIDE_HI) begin
        next_rdata = stride_hi;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= OCSC_LOAD;
      idx <= 3'h0;
      load_valid <= 1'b0;
      load_idx <= 3'h0;
      soft_rst <= 1'b0;
      for (int i = 0; i < `OCSC_CORR_BYTES; i++) begin
        corr[i] <= 8'h00;
      end
      stride_lo <= 8'h00;
      stride_hi <= 8'h00;
      tally <= `OCSC_TALLY_RESET;
      tally_hi_hold <= 8'h00;
      reg_rdata <= 8'h00;
      foc_start <= 1'b0;
      busy <= 1'b1;
      stride_setting <= 11'h000;
      tally_en <= 1'b0;
    end else begin
      st <= next_st;
      idx <= next_idx;
      load_valid <= next_load_valid;
      load_idx <= next_load_idx;
      soft_rst <= next_soft_rst;
      for (int i = 0; i < `OCSC_CORR_BYTES; i++) begin
        corr[i] <= next_corr[i];
      end
      stride_lo <= next_stride_lo;
      stride_hi <= next_stride_hi;
      tally <= next_tally;
      tally_hi_hold <= next_tally_hi_hold;
      reg_rdata <= next_rdata;
      foc_start <= next_foc_start;
      busy <= next_st != OCSC_IDLE || next_load_valid;
      stride_setting <= {next_stride_hi[2:0], next_stride_lo};
      tally_en <= next_stride_hi[`OCSC_BIT_TALLY_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-axis correction datapaths
  logic signed [15:0] raw_in [0:5];
  logic signed [15:0] fix_out [0:5];
  logic signed [9:0] corr_ext [0:5];
  logic axis_en [0:5];
  assign raw_in[0] = acc_in_x;
  assign raw_in[1] = acc_in_y;
  assign raw_in[2] = acc_in_z;
  assign raw_in[3] = gyr_in_x;
  assign raw_in[4] = gyr_in_y;
  assign raw_in[5] = gyr_in_z;
  assign acc_out_x = fix_out[0];
  assign acc_out_y = fix_out[1];
  assign acc_out_z = fix_out[2];
  assign gyr_out_x = fix_out[3];
  assign gyr_out_y = fix_out[4];
  assign gyr_out_z = fix_out[5];

  for (genvar a = 0; a < 6; a++) begin : g_axis
    if (a < 3) begin : g_acc
      assign corr_ext[a] = {{2{corr[a][7]}}, corr[a]};
      assign axis_en[a] = corr[`OCSC_IDX_ENABLES][`OCSC_BIT_ACCEL_EN];
    end else begin : g_gyr
      assign corr_ext[a] = {corr[`OCSC_IDX_ENABLES][2*(a-3) +: 2],
                            corr[a]};
      assign axis_en[a] = corr[`OCSC_IDX_ENABLES][`OCSC_BIT_GYRO_EN];
    end
    ocsc_apply u_apply (
      .clk(clk),
      .sys_rst(sys_rst),
      .en(axis_en[a]),
      .corr(corr_ext[a]),
      .raw(raw_in[a]),
      .fixed(fix_out[a])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  tally_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    is_cmd && reg_wdata == `OCSC_CMD_TALLY_CLR |=> tally == 16'h0000)
    else $error("step tally not cleared");
  tally_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !step_seen && !is_cmd |=> $stable(tally))
    else $error("step tally moved without a step");
  tally_inc_a: assert property (@(posedge clk) disable iff (sys_rst)
    step_seen && stride_hi[3] && !is_cmd |=> tally == $past(tally) + 16'h1)
    else $error("step tally did not advance by one");
  acc_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    !corr[6][6] |=> acc_out_x == $past(acc_in_x))
    else $error("accel altered while disabled");
  corr_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && reg_addr == 8'h71 && !load_valid |=> corr[0] == $past(reg_wdata))
    else $error("correction write not direct");
  foc_ld_a: assert property (@(posedge clk) disable iff (sys_rst)
    foc_done && !reg_wr && !load_valid |=> corr[3] == $past(foc_result[31:24]))
    else $error("calibration result not stored");
  soft_rld_a: assert property (@(posedge clk) disable iff (sys_rst)
    is_cmd && reg_wdata == 8'hB6 && st == OCSC_IDLE |-> ##2 st == OCSC_LOAD)
    else $error("soft reset did not reload");
  store_len_a: assert property (@(posedge clk) disable iff (sys_rst || soft_rst)
    st == OCSC_IDLE ##1 st == OCSC_STORE |-> ##7 st == OCSC_IDLE)
    else $error("store sequence wrong length");
  hi_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    stride_hi[7:4] == 4'h0)
    else $error("reserved detector bits set");
endmodule
`default_nettype wire

// >>> hw/ocsc_consts.svh
// constants for the offset compensation and step count register bank
`ifndef OCSC_CONSTS_SVH
`define OCSC_CONSTS_SVH
`define OCSC_ADDR_CORR_BASE 8'h71
`define OCSC_ADDR_CORR_LAST 8'h77
`define OCSC_ADDR_TALLY_LO 8'h78
`define OCSC_ADDR_TALLY_HI 8'h79
`define OCSC_ADDR_STRIDE_LO 8'h7A
`define OCSC_ADDR_STRIDE_HI 8'h7B
`define OCSC_ADDR_CMD 8'h7E
`define OCSC_CMD_FOC 8'h03
`define OCSC_CMD_PROG_NVM 8'hA0
`define OCSC_CMD_TALLY_CLR 8'hB2
`define OCSC_CMD_SOFTRESET 8'hB6
`define OCSC_CORR_BYTES 7
`define OCSC_IDX_ENABLES 3'h6
`define OCSC_BIT_GYRO_EN 7
`define OCSC_BIT_ACCEL_EN 6
`define OCSC_BIT_TALLY_EN 3
`define OCSC_STRIDE_HI_MASK 8'h0F
`define OCSC_TALLY_RESET 16'h0000
`endif

// >>> hw/ocsc_nvm_mem.sv
// seven-byte non-volatile backing store with registered read data
`default_nettype none
module ocsc_nvm_mem (
  input wire logic clk, // system clock
  input wire logic wr_en, // store one byte
  input wire logic [2:0] addr, // byte index
  input wire ocsc_pkg::ocsc_byte_t wr_data, // byte to store
  output ocsc_pkg::ocsc_byte_t rd_data // registered read byte
);
  import ocsc_pkg::*;
  ocsc_byte_t mem [0:6];
  ocsc_byte_t next_rd_data;
  always_comb begin
    next_rd_data = (addr < 3'h7) ? mem[addr] : 8'h00;
  end
  always_ff @(posedge clk) begin
    if (wr_en && addr < 3'h7) begin
      mem[addr] <= wr_data;
    end
    rd_data <= next_rd_data;
  end
endmodule
`default_nettype wire

// >>> hw/ocsc_pkg.sv
// types shared by the offset compensation and step count bank
`default_nettype none
package ocsc_pkg;
  typedef enum logic [1:0] {OCSC_IDLE, OCSC_LOAD, OCSC_STORE} ocsc_nvm_st_t;
  typedef logic [7:0] ocsc_byte_t;
endpackage
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the offset compensation and step count bank
`default_nettype none
`include "ocsc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ocsc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  ocsc_byte_t reg_wdata = 8'h00;
  ocsc_byte_t reg_rdata;
  logic step_seen = 1'b0;
  logic foc_done = 1'b0;
  logic [55:0] foc_result = 56'h01_66_55_44_33_22_11;
  logic foc_start, busy, tally_en, fs;
  logic signed [15:0] acc_in_x = 16'sh0100;
  logic signed [15:0] acc_in_y = 16'sh0100;
  logic signed [15:0] acc_in_z = 16'sh0100;
  logic signed [15:0] gyr_in_x = 16'sh1000;
  logic signed [15:0] gyr_in_y = 16'sh1000;
  logic signed [15:0] gyr_in_z = 16'sh1000;
  logic signed [15:0] acc_out_x, acc_out_y, acc_out_z;
  logic signed [15:0] gyr_out_x, gyr_out_y, gyr_out_z;
  logic [10:0] stride_setting;
  logic [7:0] corr [7] = '{8'h05, 8'hFB, 8'h80, 8'hF0, 8'h23, 8'h00, 8'hE7};
  logic [7:0] lo_set [3] = '{8'h15, 8'h2D, 8'h1D};
  logic [7:0] hi_set [3] = '{8'h03, 8'h00, 8'h07};
  logic ge, ae;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  ocsc_bank dut_u (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .step_seen(step_seen), .foc_done(foc_done),
    .foc_result(foc_result), .foc_start(foc_start), .busy(busy),
    .acc_in_x(acc_in_x), .acc_in_y(acc_in_y), .acc_in_z(acc_in_z),
    .gyr_in_x(gyr_in_x), .gyr_in_y(gyr_in_y), .gyr_in_z(gyr_in_z),
    .acc_out_x(acc_out_x), .acc_out_y(acc_out_y), .acc_out_z(acc_out_z),
    .gyr_out_x(gyr_out_x), .gyr_out_y(gyr_out_y), .gyr_out_z(gyr_out_z),
    .stride_setting(stride_setting), .tally_en(tally_en));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // the bench is slow to time out: the run needs under two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(nm, {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // waits out a nonvolatile load or store under a bound
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(negedge clk);
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("busy", {15'h0, busy}, 16'h0000);
  endtask

  task automatic steps(input int n);
    repeat (n) begin
      @(negedge clk);
      step_seen = 1'b1;
      @(negedge clk);
      step_seen = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk);
    chk("busy in reset", {15'h0, busy}, 16'h0001);
    sys_rst = 1'b0;
    wait_idle();
    rdchk("tally lo reset", `OCSC_ADDR_TALLY_LO, 8'h00);
    rdchk("tally hi reset", `OCSC_ADDR_TALLY_HI, 8'h00);
    rdchk("unmapped", 8'h7C, 8'h00);
    $display("test reset done");

    for (int i = 0; i < 7; i++) wr(`OCSC_ADDR_CORR_BASE + 8'(i), corr[i]);
    for (int i = 0; i < 7; i++)
      rdchk("corr byte", `OCSC_ADDR_CORR_BASE + 8'(i), corr[i]);
    for (int k = 0; k < 4; k++) begin
      ge = k[1];
      ae = k[0];
      wr(`OCSC_ADDR_CORR_LAST, {ge, ae, 6'h27});
      repeat (2) @(negedge clk);
      chk("acc x", acc_out_x, ae ? 16'h0105 : 16'h0100);
      chk("acc y", acc_out_y, ae ? 16'h00FB : 16'h0100);
      chk("acc z", acc_out_z, ae ? 16'h0080 : 16'h0100);
      chk("gyr x", gyr_out_x, ge ? 16'h0FF0 : 16'h1000);
      chk("gyr y", gyr_out_y, ge ? 16'h1123 : 16'h1000);
      chk("gyr z", gyr_out_z, ge ? 16'h0E00 : 16'h1000);
    end
    $display("test compensation done");

    wr(`OCSC_ADDR_CMD, `OCSC_CMD_PROG_NVM);
    wait_idle();
    wr(`OCSC_ADDR_CORR_BASE, 8'h33);
    rdchk("corr direct", `OCSC_ADDR_CORR_BASE, 8'h33);
    wr(`OCSC_ADDR_CMD, `OCSC_CMD_SOFTRESET);
    wait_idle();
    for (int i = 0; i < 7; i++)
      rdchk("corr reload", `OCSC_ADDR_CORR_BASE + 8'(i), corr[i]);
    $display("test store reload done");

    wr(`OCSC_ADDR_CMD, `OCSC_CMD_FOC);
    fs = foc_start;
    @(negedge clk);
    fs = fs | foc_start;
    chk("foc start", {15'h0, fs}, 16'h0001);
    @(negedge clk);
    foc_done = 1'b1;
    @(negedge clk);
    foc_done = 1'b0;
    for (int i = 0; i < 7; i++)
      rdchk("foc corr", `OCSC_ADDR_CORR_BASE + 8'(i),
            foc_result[8*i +: 8]);
    $display("test calibration done");

    for (int i = 0; i < 3; i++) begin
      wr(`OCSC_ADDR_STRIDE_LO, lo_set[i]);
      wr(`OCSC_ADDR_STRIDE_HI, hi_set[i]);
      @(negedge clk);
      chk("stride", {5'h0, stride_setting},
          {5'h0, hi_set[i][2:0], lo_set[i]});
      chk("tally en off", {15'h0, tally_en}, 16'h0000);
    end
    steps(3);
    rdchk("no count", `OCSC_ADDR_TALLY_LO, 8'h00);
    wr(`OCSC_ADDR_STRIDE_HI, 8'hFF);
    rdchk("stride hi mask", `OCSC_ADDR_STRIDE_HI, 8'h0F);
    chk("tally en on", {15'h0, tally_en}, 16'h0001);
    steps(255);
    rdchk("tally lo ff", `OCSC_ADDR_TALLY_LO, 8'hFF);
    steps(1);
    rdchk("tally hi latched", `OCSC_ADDR_TALLY_HI, 8'h00);
    wr(`OCSC_ADDR_TALLY_LO, 8'h55);
    rdchk("tally lo 100", `OCSC_ADDR_TALLY_LO, 8'h00);
    rdchk("tally hi 100", `OCSC_ADDR_TALLY_HI, 8'h01);
    wr(`OCSC_ADDR_CMD, `OCSC_CMD_TALLY_CLR);
    rdchk("tally clr lo", `OCSC_ADDR_TALLY_LO, 8'h00);
    rdchk("tally clr hi", `OCSC_ADDR_TALLY_HI, 8'h00);
    $display("test step count done");
    close_out();
  end
endmodule
`default_nettype wire
